// [logic/edge_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser plus rising-edge detect on the synchronised level
module edge_sync (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic d_i,
    output logic rise_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // First flop read only by the second
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else if (ce_i) begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign rise_o = s2_r & ~s3_r;
endmodule : edge_sync

// [logic/prescaler.sv]
`timescale 1ns/1ps
// Divides a tick stream by 1, 2, 4 or 8
module prescaler
    import timer_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    logic [2:0] cnt_r;
    logic [2:0] mask;
    // Mask picks how many low bits must be all ones
    always_comb begin
        unique case (sel_i)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            2'h3: mask = PS_MAX;
        endcase
    end
    assign tick_o = tick_i & ((cnt_r & mask) == mask);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 3'h0;
        end else if (ce_i && tick_i) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end
endmodule : prescaler

// [logic/timer_control_register.sv]
`timescale 1ns/1ps
// Timer control register with AHB-Lite access and the count-enable logic
module timer_control_register
    import timer_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic external_count_input_i,
    input wire logic gate_input_pin_i,
    input wire logic second_comparator_output_i,
    input wire logic internal_oscillator_i,
    input wire logic clock_output_pin_en_i,
    input wire logic [1:0] prescale_select_o_unused_i,
    output logic [1:0] prescale_select_o,
    output logic clock_source_select_o,
    output logic sync_bypass_bit_o,
    output logic gate_enable_bit_o,
    output logic gate_polarity_select_o,
    output logic timer_run_bit_o,
    output logic low_power_crystal_mode_o,
    output logic count_tick_o,
    output logic raw_count_clk_o
);
    logic [7:0] timer_control_r;
    logic gate_source_select_r;
    logic wr_pend_r;
    logic [31:0] addr_r;
    logic [31:0] rdata_r;
    logic [1:0] inst_cnt_r;
    logic inst_tick;
    logic ext_rise;
    logic src_tick;
    logic gate_sig;
    logic gate_active;
    logic count_en;
    logic ps_tick;
    logic accept;

    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ ||
                    htrans == HTRANS_SEQ);

    // Address phase capture; zero wait states
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend_r <= 1'b0;
            addr_r <= 32'h0000_0000;
        end else if (ce_i && hready) begin
            wr_pend_r <= accept && hwrite;
            addr_r <= haddr;
        end
    end

    // Control bits clear on reset and are fully writable
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer_control_r <= CTRL_RESET;
            gate_source_select_r <= 1'b0;
        end else if (ce_i && wr_pend_r) begin
            if (addr_r == CTRL_ADDR) begin
                timer_control_r <= hwdata[7:0];
            end
            if (addr_r == GATE_SRC_ADDR) begin
                gate_source_select_r <= hwdata[0];
            end
        end
    end

    // Read data registered at the address phase; unmapped reads zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (ce_i && accept && !hwrite) begin
            if (haddr == CTRL_ADDR) begin
                rdata_r <= {24'h00_0000, timer_control_r};
            end else if (haddr == GATE_SRC_ADDR) begin
                rdata_r <= {31'h0000_0000, gate_source_select_r};
            end else if (haddr == STATUS_ADDR) begin
                rdata_r <= {29'h0000_0000, low_power_crystal_mode_o,
                            gate_active, count_en};
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end
    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Field outputs
    assign prescale_select_o = timer_control_r[PS_LO+1:PS_LO];
    assign clock_source_select_o = timer_control_r[BIT_SRC];
    assign sync_bypass_bit_o = timer_control_r[BIT_BYPASS];
    assign gate_enable_bit_o = timer_control_r[BIT_GATE_EN];
    assign gate_polarity_select_o = timer_control_r[BIT_GATE_POL];
    assign timer_run_bit_o = timer_control_r[BIT_RUN];

    // Crystal only usable when running internal osc without clock out
    assign low_power_crystal_mode_o = internal_oscillator_i &&
        !clock_output_pin_en_i && timer_control_r[BIT_OSC_EN];

    // Instruction clock tick once every four system clocks
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            inst_cnt_r <= 2'h0;
        end else if (ce_i) begin
            inst_cnt_r <= inst_cnt_r + 2'h1;
        end
    end
    assign inst_tick = (inst_cnt_r == INSTR_DIV);

    edge_sync u_ext_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .d_i(external_count_input_i),
        .rise_o(ext_rise)
    );

    // Unsynchronised path is handed out raw; this domain only sees sync ticks
    assign raw_count_clk_o = clock_source_select_o && sync_bypass_bit_o &&
        external_count_input_i;
    assign src_tick = clock_source_select_o ? ext_rise : inst_tick;

    // Gate source and polarity
    assign gate_sig = gate_source_select_r ? second_comparator_output_i :
        gate_input_pin_i;
    assign gate_active = gate_polarity_select_o ? gate_sig : !gate_sig;
    assign count_en = timer_run_bit_o &&
        (!gate_enable_bit_o || gate_active);

    prescaler u_ps (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .tick_i(src_tick && count_en),
        .sel_i(prescale_select_o),
        .tick_o(ps_tick)
    );

    // Stopped timer produces no ticks, so the count holds
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_tick_o <= 1'b0;
        end else if (ce_i) begin
            count_tick_o <= ps_tick;
        end
    end
endmodule : timer_control_register

// [logic/timer_ctrl_pkg.sv]
// Contract
// - Gate polarity 1 counts while gate high, 0 while gate low.
// - With run set, gate enable 1 counts only on active gate, else always.
// - Prescale field 11/10/01/00 divides count clock by 8/4/2/1.
// - Internal oscillator without clock output: osc enable bit drives crystal.
// - Any other oscillator configuration ignores osc enable, crystal stays off.
// - External source: bypass 1 feeds raw edges, 0 synchronises first; the count here always uses synced edges, bypass only gates raw_count_clk_o.
// - Internal source ignores bypass bit and uses internal clock.
// - Source select 1 advances on rising edges of external count input.
// - Source select 0 uses instruction clock, system clock divided by four.
// - Run bit set enables timer, clear stops it and holds count.
// - Gate comes from gate pin or second comparator, chosen by software.
package timer_ctrl_pkg;
    localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
    localparam logic [31:0] GATE_SRC_ADDR = 32'h0000_0004;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0008;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int BIT_RUN = 0;
    localparam int BIT_SRC = 1;
    localparam int BIT_BYPASS = 2;
    localparam int BIT_OSC_EN = 3;
    localparam int PS_LO = 4;
    localparam int BIT_GATE_EN = 6;
    localparam int BIT_GATE_POL = 7;
    localparam logic [1:0] INSTR_DIV = 2'h3; // Instruction clock: divide by 4
    localparam logic [2:0] PS_MAX = 3'h7;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage : timer_ctrl_pkg

// [tb/timer_control_register_tb.sv]
`timescale 1ns/1ps
// Programs the control register over the bus and counts timer ticks
module timer_control_register_tb;
    import timer_ctrl_pkg::*;
    logic clk_i = 1'b0, rstn_i = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic ext = 1'b0, gp = 1'b0, cmp = 1'b0, iosc = 1'b0, ckout = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, low_power_crystal_mode_o, count_tick_o;
    logic [1:0] ps;
    logic src, byp, gen, gpol, run;
    int n_fail = 0, checked = 0;
    // Gate cases: control, source, pin, comparator, ticks expected
    // Last case: gate active but run clear, so nothing counts
    logic [11:0] gv [8] = '{12'h414, 12'h413, 12'hC15, 12'hC12, 12'hC1B,
        12'hC1C, 12'h015, 12'h402};
    timer_control_register DUT (.clk_i, .rstn_i, .ce_i(1'b1), .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp(), .external_count_input_i(ext),
        .gate_input_pin_i(gp), .second_comparator_output_i(cmp),
        .internal_oscillator_i(iosc), .clock_output_pin_en_i(ckout),
        .prescale_select_o_unused_i(2'h0), .prescale_select_o(ps),
        .clock_source_select_o(src), .sync_bypass_bit_o(byp),
        .gate_enable_bit_o(gen), .gate_polarity_select_o(gpol),
        .timer_run_bit_o(run),
        .low_power_crystal_mode_o, .count_tick_o, .raw_count_clk_o());
    initial forever #25 clk_i = ~clk_i;
    task chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task complete_run;
        $display("mismatches %0d comparisons %0d", n_fail, checked);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // One bus transfer; a slave that never answers ends the run
    task xfer(input logic w, input logic [31:0] a, d);
        int i;
        @(posedge clk_i);
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (hreadyout === 1'b1 && htrans == 2'h0) break;
            if (hreadyout === 1'b1) begin
                htrans <= 2'h0;
                hwdata <= d;
            end
        end
        rv = hrdata;
        if (i == 20) begin
            n_fail++;
            complete_run;
        end
    endtask : xfer
    // Settle 40 cycles, then count ticks over 64; x toggles the pin
    task cnt(input int e, input logic x);
        int k;
        k = 0;
        for (int i = 0; i < 104; i++) begin
            @(posedge clk_i);
            ext <= x && i >= 40 && i < 96 && i[2];
            if (i >= 40 && count_tick_o === 1'b1) k++;
        end
        if (e >= 0) chk("ticks", k, e);
    endtask : cnt
    initial begin
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        xfer(1'b0, CTRL_ADDR, 32'h0);
        chk("control", rv, 32'h0);
        xfer(1'b1, CTRL_ADDR, 32'hFF);
        xfer(1'b0, CTRL_ADDR, 32'h0);
        chk("control", rv, 32'hFF);
        chk("fields", {gpol, gen, ps, 1'b0, byp, src, run}, 32'hF7);
        xfer(1'b0, 32'h10, 32'h0);
        chk("unmapped", rv, 32'h0);
        $display("register test done");
        for (int p = 0; p < 4; p++) begin
            xfer(1'b1, CTRL_ADDR, 32'h1 | (p << 4));
            cnt(16 >> p, 1'b0);
        end
        xfer(1'b1, CTRL_ADDR, 32'h0);
        cnt(0, 1'b0);
        $display("prescale test done");
        foreach (gv[j]) begin
            xfer(1'b1, GATE_SRC_ADDR, gv[j][3]);
            xfer(1'b1, CTRL_ADDR, gv[j][11:4]);
            gp <= gv[j][2];
            cmp <= gv[j][1];
            cnt(gv[j][0] ? 16 : 0, 1'b0);
            xfer(1'b0, STATUS_ADDR, 32'h0);
            chk("count enable", rv[0], gv[j][0]);
        end
        $display("gate test done");
        xfer(1'b1, CTRL_ADDR, 32'h03);
        cnt(7, 1'b1);
        xfer(1'b1, CTRL_ADDR, 32'h07);
        cnt(-1, 1'b1);
        xfer(1'b1, CTRL_ADDR, 32'h08);
        iosc <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("crystal", low_power_crystal_mode_o, 1'b1);
        ckout <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("crystal", low_power_crystal_mode_o, 1'b0);
        $display("clock source test done");
        complete_run;
    end
endmodule : timer_control_register_tb
bind timer_control_register timer_ctrl_chk CHK (.*);

// [tb/timer_ctrl_chk.sv]
`timescale 1ns/1ps
// Bus answer and count path checks at the ports of the timer block
module timer_ctrl_chk
    import timer_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] haddr,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic external_count_input_i,
    input wire logic internal_oscillator_i,
    input wire logic clock_output_pin_en_i,
    input wire logic clock_source_select_o,
    input wire logic sync_bypass_bit_o,
    input wire logic timer_run_bit_o,
    input wire logic low_power_crystal_mode_o,
    input wire logic count_tick_o,
    input wire logic raw_count_clk_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Control write: address phase, data phase, then the bits land
    sequence s_wr;
        hsel && htrans == HTRANS_NONSEQ && hwrite && haddr == CTRL_ADDR ##1 1;
    endsequence
    property p_wr;
        s_wr |=> {clock_source_select_o, timer_run_bit_o} == $past(hwdata[1:0]);
    endproperty
    a_wr: assert property (p_wr) else $error("control write lost");
    property p_rdy; hreadyout; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state seen");
    property p_resp; !hresp; endproperty
    a_resp: assert property (p_resp) else $error("error response seen");
    // Four stopped cycles drain the pipeline, so no tick may follow
    property p_stop; !timer_run_bit_o [*4] |-> !count_tick_o; endproperty
    a_stop: assert property (p_stop) else $error("tick while stopped");
    // Instruction clock is a quarter rate, ticks stay four apart
    property p_int;
        count_tick_o && !clock_source_select_o |=> !count_tick_o [*3];
    endproperty
    a_int: assert property (p_int) else $error("internal tick too soon");
    property p_raw0; !clock_source_select_o |-> !raw_count_clk_o; endproperty
    a_raw0: assert property (p_raw0) else $error("raw clock leaks");
    property p_raw1;
        clock_source_select_o && sync_bypass_bit_o
            |-> raw_count_clk_o == external_count_input_i;
    endproperty
    a_raw1: assert property (p_raw1) else $error("raw clock wrong");
    property p_lp;
        !internal_oscillator_i || clock_output_pin_en_i
            |-> !low_power_crystal_mode_o;
    endproperty
    a_lp: assert property (p_lp) else $error("crystal not disabled");
endmodule : timer_ctrl_chk
